// ==== logic/idb_pkg.sv ====
// Constants, register map and state type of the instrument-bus DMA engine.
// Assumes one system clock for the register bus, the memory bus and the chip port.
package idb_pkg;

   // ************************************************************
   // Sizes
   // ************************************************************
   localparam int unsigned BUF_BYTES  = 32;
   localparam int unsigned LINE_WORDS = 8;
   localparam int unsigned WORD_BYTES = 4;
   localparam int unsigned CNT_W      = 16;
   localparam int unsigned PTR_W      = 6;
   localparam logic [5:0]  PTR_FULL   = 6'h20;

   // ************************************************************
   // Register byte offsets
   // ************************************************************
   localparam logic [7:0] OFS_ADDR   = 8'h00;
   localparam logic [7:0] OFS_COUNT  = 8'h04;
   localparam logic [7:0] OFS_MATCH  = 8'h08;
   localparam logic [7:0] OFS_CTRL   = 8'h0C;
   localparam logic [7:0] OFS_ENABLE = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int unsigned CTRL_DIR     = 0;
   localparam int unsigned CTRL_MATCHEN = 1;
   localparam int unsigned CTRL_FLUSH   = 2;
   localparam int unsigned EN_DMA       = 0;
   localparam int unsigned EN_INTR      = 1;
   localparam int unsigned ST_BUSY      = 0;
   localparam int unsigned ST_TC        = 1;
   localparam int unsigned ST_MATCH     = 2;
   localparam int unsigned ST_BUSERR    = 3;
   localparam int unsigned ST_LEVEL     = 8;
   localparam logic [31:0] RST_ADDR     = 32'h0000_0000;
   localparam logic [15:0] RST_COUNT    = 16'h0000;
   localparam logic [7:0]  RST_MATCH    = 8'h00;
   localparam logic        DIR_IN       = 1'b0;
   localparam logic        DIR_OUT      = 1'b1;

   typedef enum logic [2:0] {
      ST_IDLE, ST_CHECK, ST_CHIP_REQ, ST_CHIP_REL, ST_MEM_SETUP, ST_MEM_WAIT
   } idb_state_e;

endpackage : idb_pkg

// ==== logic/idb_byte_buf.sv ====
// Byte buffer of the DMA engine: writes one to four bytes, reads four bytes.
// Assumes indices wrap modulo the buffer size and the writer never overruns it.
`timescale 1ns/10ps
`default_nettype none
module idb_byte_buf (
   input  wire logic        hclk,
   input  wire logic        wr_en,
   input  wire logic [4:0]  wr_idx,
   input  wire logic [2:0]  wr_n,
   input  wire logic [31:0] wr_data,
   input  wire logic [4:0]  rd_idx,
   output logic      [31:0] rd_data
);

   // ************************************************************
   // Storage
   // ************************************************************
   // Single array shared by both sides; the engine never lets them work at once
   logic [7:0] mem [idb_pkg::BUF_BYTES];

   always_ff @(posedge hclk) begin
      for (int i = 0; i < 4; i++) begin
         if (wr_en && (3'(i) < wr_n)) begin
            mem[5'(wr_idx + 5'(i))] <= wr_data[8*i +: 8];
         end
      end
   end

   for (genvar g = 0; g < 4; g++) begin : g_rd
      assign rd_data[8*g +: 8] = mem[5'(rd_idx + 5'(g))];
   end

endmodule : idb_byte_buf
`default_nettype wire

// ==== logic/idb_dma.sv ====
// DMA engine between an instrument-bus controller chip and system memory.
// Assumes the chip port and memory bus run on hclk; chip pins are synchronised here.
// Function
// - 32-byte buffer, whole lines to memory
// - aligned line moves as eight 32-bit words
// - chip side moves single bytes
// - memory run continues until buffer empty/full
// - no memory access during chip transfer
// - direction zero means chip to memory
// - direction one means memory to chip
// - start right after enable write; interrupt enable
// - inbound count per chip byte, ends at zero
// - inbound ends on enabled tag match
// - inbound ends on memory write error
// - inbound buffer full writes to memory
// - terminal count flushes partial buffer
// - match stops fetching and flushes buffer
// - chip interrupt flushes without ending
// - debug flush bit forces flush
// - outbound count per memory byte, ends zero
// - outbound ends only on count or error
// - compare each inbound chip byte with match value
// - re-enable after match resumes, no reinit
// - count write clears the buffer
// - bus error clears enable, sets sticky error
// - flush held while chip interrupt persists
// - flush acts only inbound
`timescale 1ns/10ps
`default_nettype none
module idb_dma (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             mem_req,
   output logic             mem_we,
   output logic      [31:0] mem_addr,
   output logic      [3:0]  mem_be,
   output logic      [31:0] mem_wdata,
   input  wire logic [31:0] mem_rdata,
   input  wire logic        mem_ack,
   input  wire logic        mem_err,
   output logic             chip_xfer_request,
   input  wire logic        chip_xfer_grant,
   input  wire logic [7:0]  chip_data_in,
   output logic      [7:0]  chip_data_out,
   output logic             chip_data_oe,
   input  wire logic        chip_irq,
   output logic             dma_irq
);

   // ************************************************************
   // Declarations
   // ************************************************************
   idb_pkg::idb_state_e state, next_state;
   logic [31:0] addr, next_addr;
   logic [15:0] count, next_count;
   logic [7:0]  match_val, next_match_val;
   logic        dir, next_dir;
   logic        match_en, next_match_en;
   logic        flush, next_flush;
   logic        dmaen, next_dmaen;
   logic        intr_en, next_intr_en;
   logic        tc_done, next_tc_done;
   logic        match_done, next_match_done;
   logic        buserr, next_buserr;
   logic        term_tc, next_term_tc;
   logic        term_match, next_term_match;
   logic [5:0]  wptr, next_wptr;
   logic [5:0]  rptr, next_rptr;
   logic [2:0]  xfer_n, next_xfer_n;
   logic        dp_wr, next_dp_wr;
   logic [7:0]  dp_ofs, next_dp_ofs;
   logic [31:0] next_hrdata;
   logic        next_mem_req, next_mem_we;
   logic [31:0] next_mem_addr, next_mem_wdata;
   logic [3:0]  next_mem_be;
   logic        next_chip_req, next_chip_oe;
   logic [7:0]  next_chip_dout;
   logic        next_dma_irq;
   logic        grant_q1, grant_q2, irq_q1, irq_q2;
   logic [7:0]  din_q1, din_q2;
   logic        buf_wr;
   logic [4:0]  buf_wr_idx;
   logic [2:0]  buf_wr_n;
   logic [31:0] buf_wr_data, buf_rd_data;
   logic [4:0]  buf_rd_idx;
   logic        ap_valid, flush_lvl, empty;
   logic [1:0]  ofs;
   logic [2:0]  room, nbytes;
   logic [5:0]  avail;

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [31:0] reg_read(input logic [7:0] o, input logic [31:0] a, input logic [15:0] c,
                                             input logic [7:0] m, input logic [2:0] ctl, input logic [1:0] en,
                                             input logic [3:0] st, input logic [5:0] lvl);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (o)
         idb_pkg::OFS_ADDR:   v = a;
         idb_pkg::OFS_COUNT:  v = {16'h0000, c};
         idb_pkg::OFS_MATCH:  v = {24'h00_0000, m};
         idb_pkg::OFS_CTRL:   v = {29'h0000_0000, ctl};
         idb_pkg::OFS_ENABLE: v = {30'h0000_0000, en};
         idb_pkg::OFS_STATUS: v = {18'h0_0000, lvl, 4'h0, st};
         default:             v = 32'h0000_0000;
      endcase
      return v;
   endfunction : reg_read

   function automatic logic [2:0] min3(input logic [2:0] a, input logic [5:0] b);
      return (6'(a) < b) ? a : b[2:0];
   endfunction : min3

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         grant_q1 <= 1'b0;
         grant_q2 <= 1'b0;
         irq_q1   <= 1'b0;
         irq_q2   <= 1'b0;
         din_q1   <= 8'h00;
         din_q2   <= 8'h00;
      end else begin
         grant_q1 <= chip_xfer_grant;
         grant_q2 <= grant_q1;
         irq_q1   <= chip_irq;
         irq_q2   <= irq_q1;
         din_q1   <= chip_data_in;
         din_q2   <= din_q1;
      end
   end

   idb_byte_buf u_buf (
      .hclk    (hclk),
      .wr_en   (buf_wr),
      .wr_idx  (buf_wr_idx),
      .wr_n    (buf_wr_n),
      .wr_data (buf_wr_data),
      .rd_idx  (buf_rd_idx),
      .rd_data (buf_rd_data)
   );

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ************************************************************
   // Next-state logic
   // ************************************************************
   always_comb begin
      ap_valid = hsel && htrans[1] && hready;
      flush_lvl = (dir == idb_pkg::DIR_IN) && (flush || irq_q2);
      empty     = (wptr == rptr);
      ofs       = addr[1:0];
      room      = 3'(idb_pkg::WORD_BYTES) - {1'b0, ofs};
      avail     = wptr - rptr;
      nbytes    = 3'h0;
      next_state      = state;
      next_addr       = addr;
      next_count      = count;
      next_match_val  = match_val;
      next_dir        = dir;
      next_match_en   = match_en;
      next_flush      = flush;
      next_dmaen      = dmaen;
      next_intr_en    = intr_en;
      next_tc_done    = tc_done;
      next_match_done = match_done;
      next_buserr     = buserr;
      next_term_tc    = term_tc;
      next_term_match = term_match;
      next_wptr       = wptr;
      next_rptr       = rptr;
      next_xfer_n     = xfer_n;
      next_mem_req    = mem_req;
      next_mem_we     = mem_we;
      next_mem_addr   = mem_addr;
      next_mem_be     = mem_be;
      next_mem_wdata  = mem_wdata;
      next_chip_req   = chip_xfer_request;
      next_chip_oe    = chip_data_oe;
      next_chip_dout  = chip_data_out;
      buf_wr      = 1'b0;
      buf_wr_idx  = wptr[4:0];
      buf_wr_n    = 3'h1;
      buf_wr_data = {24'h00_0000, din_q2};
      buf_rd_idx  = rptr[4:0];
      // Bus: read data is sampled at the address phase
      next_dp_wr  = ap_valid && hwrite;
      next_dp_ofs = haddr[7:0];
      next_hrdata = ap_valid ? reg_read(haddr[7:0], addr, count, match_val, {flush, match_en, dir},
                                        {intr_en, dmaen}, {buserr, match_done, tc_done, state != idb_pkg::ST_IDLE},
                                        wptr - rptr) : hrdata;

      unique case (state)
         idb_pkg::ST_IDLE: begin
            if (dmaen || (flush_lvl && !empty)) begin
               next_state = idb_pkg::ST_CHECK;
            end
         end
         idb_pkg::ST_CHECK: begin
            if (dir == idb_pkg::DIR_IN) begin
               // full buffer goes out; flush partial
               if (!empty && (term_tc || term_match || wptr == idb_pkg::PTR_FULL || flush_lvl)) begin
                  next_state = idb_pkg::ST_MEM_SETUP;
               end else if (!dmaen) begin
                  next_state = idb_pkg::ST_IDLE;
               end else if (term_tc || term_match) begin
                  next_tc_done    = term_tc;
                  next_match_done = term_match;
                  next_term_tc    = 1'b0;
                  next_term_match = 1'b0;
                  next_dmaen      = 1'b0;
                  next_state      = idb_pkg::ST_IDLE;
               end else if (count == 16'h0000) begin
                  next_term_tc = 1'b1;
               end else begin
                  next_state = idb_pkg::ST_CHIP_REQ;
               end
            end else if (!dmaen) begin
               next_state = idb_pkg::ST_IDLE;
            end else if (!empty) begin
               next_chip_dout = buf_rd_data[7:0];
               next_chip_oe   = 1'b1;
               next_state     = idb_pkg::ST_CHIP_REQ;
            end else begin
               next_wptr = 6'h00;
               next_rptr = 6'h00;
               if (count == 16'h0000) begin
                  next_tc_done = 1'b1;
                  next_dmaen   = 1'b0;
                  next_state   = idb_pkg::ST_IDLE;
               end else begin
                  next_state = idb_pkg::ST_MEM_SETUP;
               end
            end
         end
         idb_pkg::ST_CHIP_REQ: begin
            next_chip_req = 1'b1;
            if (grant_q2) begin
               next_chip_req = 1'b0;
               next_chip_oe  = 1'b0;
               next_state    = idb_pkg::ST_CHIP_REL;
               if (dir == idb_pkg::DIR_IN) begin
                  // one byte from chip into buffer
                  buf_wr     = 1'b1;
                  next_wptr  = wptr + 6'h01;
                  next_count = count - 16'h0001;
                  if (match_en && din_q2 == match_val) begin
                     next_term_match = 1'b1;
                  end
               end else begin
                  next_rptr = rptr + 6'h01;
               end
            end
         end
         idb_pkg::ST_CHIP_REL: begin
            if (!grant_q2) begin
               next_state = idb_pkg::ST_CHECK;
            end
         end
         idb_pkg::ST_MEM_SETUP: begin
            // word accesses, aligned lines give eight
            if (dir == idb_pkg::DIR_IN) begin
               nbytes = min3(room, avail);
               next_mem_we    = 1'b1;
               next_mem_wdata = buf_rd_data << (8 * ofs);
            end else begin
               nbytes = min3(min3(room, idb_pkg::PTR_FULL - wptr),
                             (count > 16'h0004) ? 6'h04 : count[5:0]);
               next_mem_we    = 1'b0;
               next_mem_wdata = 32'h0000_0000;
            end
            next_xfer_n   = nbytes;
            next_mem_be   = 4'((4'hF >> (3'h4 - nbytes)) << ofs);
            next_mem_addr = {addr[31:2], 2'b00};
            next_mem_req  = 1'b1;
            next_state    = idb_pkg::ST_MEM_WAIT;
         end
         idb_pkg::ST_MEM_WAIT: begin
            if (mem_err) begin
               next_mem_req    = 1'b0;
               next_buserr     = 1'b1;
               next_dmaen      = 1'b0;
               next_term_tc    = 1'b0;
               next_term_match = 1'b0;
               next_wptr       = 6'h00;
               next_rptr       = 6'h00;
               next_state      = idb_pkg::ST_IDLE;
            end else if (mem_ack) begin
               next_mem_req = 1'b0;
               next_addr    = addr + 32'(xfer_n);
               next_state   = idb_pkg::ST_MEM_SETUP;
               if (dir == idb_pkg::DIR_IN) begin
                  next_rptr = rptr + 6'(xfer_n);
                  if (rptr + 6'(xfer_n) == wptr) begin
                     next_wptr  = 6'h00;
                     next_rptr  = 6'h00;
                     next_state = idb_pkg::ST_CHECK;
                  end
               end else begin
                  buf_wr      = 1'b1;
                  buf_wr_n    = xfer_n;
                  buf_wr_data = mem_rdata >> (8 * ofs);
                  next_wptr   = wptr + 6'(xfer_n);
                  next_count  = count - 16'(xfer_n);
                  // fill until full or count spent
                  if (wptr + 6'(xfer_n) == idb_pkg::PTR_FULL || count == 16'(xfer_n)) begin
                     next_state = idb_pkg::ST_CHECK;
                  end
               end
            end
         end
      endcase

      // Register writes land in the data phase
      if (dp_wr) begin
         unique case (dp_ofs)
            idb_pkg::OFS_ADDR: next_addr = hwdata;
            idb_pkg::OFS_COUNT: begin
               next_count = hwdata[15:0];
               next_wptr = 6'h00;
               next_rptr = 6'h00;
            end
            idb_pkg::OFS_MATCH: next_match_val = hwdata[7:0];
            idb_pkg::OFS_CTRL: begin
               next_dir      = hwdata[idb_pkg::CTRL_DIR];
               next_match_en = hwdata[idb_pkg::CTRL_MATCHEN];
               // flush bit stored in either direction; flush_lvl lets it act only when inbound
               next_flush    = hwdata[idb_pkg::CTRL_FLUSH];
            end
            idb_pkg::OFS_ENABLE: begin
               next_dmaen   = hwdata[idb_pkg::EN_DMA];
               next_intr_en = hwdata[idb_pkg::EN_INTR];
               if (hwdata[idb_pkg::EN_DMA]) begin
                  // resume keeps address and count; error clears here
                  next_buserr     = 1'b0;
                  next_tc_done    = 1'b0;
                  next_match_done = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      next_dma_irq = next_intr_en && (next_tc_done || next_match_done || next_buserr);
   end

   // ************************************************************
   // State registers
   // ************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state             <= idb_pkg::ST_IDLE;
         addr              <= idb_pkg::RST_ADDR;
         count             <= idb_pkg::RST_COUNT;
         match_val         <= idb_pkg::RST_MATCH;
         dir               <= idb_pkg::DIR_IN;
         match_en          <= 1'b0;
         flush             <= 1'b0;
         dmaen             <= 1'b0;
         intr_en           <= 1'b0;
         tc_done           <= 1'b0;
         match_done        <= 1'b0;
         buserr            <= 1'b0;
         term_tc           <= 1'b0;
         term_match        <= 1'b0;
         wptr              <= 6'h00;
         rptr              <= 6'h00;
         xfer_n            <= 3'h0;
         dp_wr             <= 1'b0;
         dp_ofs            <= 8'h00;
         hrdata            <= 32'h0000_0000;
         mem_req           <= 1'b0;
         mem_we            <= 1'b0;
         mem_addr          <= 32'h0000_0000;
         mem_be            <= 4'h0;
         mem_wdata         <= 32'h0000_0000;
         chip_xfer_request <= 1'b0;
         chip_data_oe      <= 1'b0;
         chip_data_out     <= 8'h00;
         dma_irq           <= 1'b0;
      end else begin
         state             <= next_state;
         addr              <= next_addr;
         count             <= next_count;
         match_val         <= next_match_val;
         dir               <= next_dir;
         match_en          <= next_match_en;
         flush             <= next_flush;
         dmaen             <= next_dmaen;
         intr_en           <= next_intr_en;
         tc_done           <= next_tc_done;
         match_done        <= next_match_done;
         buserr            <= next_buserr;
         term_tc           <= next_term_tc;
         term_match        <= next_term_match;
         wptr              <= next_wptr;
         rptr              <= next_rptr;
         xfer_n            <= next_xfer_n;
         dp_wr             <= next_dp_wr;
         dp_ofs            <= next_dp_ofs;
         hrdata            <= next_hrdata;
         mem_req           <= next_mem_req;
         mem_we            <= next_mem_we;
         mem_addr          <= next_mem_addr;
         mem_be            <= next_mem_be;
         mem_wdata         <= next_mem_wdata;
         chip_xfer_request <= next_chip_req;
         chip_data_oe      <= next_chip_oe;
         chip_data_out     <= next_chip_dout;
         dma_irq           <= next_dma_irq;
      end
   end

endmodule : idb_dma
`default_nettype wire

// ==== tb/idb_dma_props.sv ====
// Port checker of the DMA engine.
// Assumes it is bound to idb_dma and sees one clock domain.
`timescale 1ns/10ps
`default_nettype none
module idb_dma_props (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        mem_req,
   input  wire logic        mem_ack,
   input  wire logic        mem_err,
   input  wire logic [31:0] mem_addr,
   input  wire logic        chip_xfer_request,
   input  wire logic        chip_xfer_grant,
   input  wire logic        chip_data_oe,
   input  wire logic        chip_irq
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_word_gap;
      mem_ack ##1 !mem_req ##1 mem_req;
   endsequence
   property p_excl; !(mem_req && chip_xfer_request); endproperty
   a_excl: assert property (p_excl) else $error("memory and chip access overlap");
   property p_hold; mem_req && !mem_ack && !mem_err |=> mem_req && $stable(mem_addr); endproperty
   a_hold: assert property (p_hold) else $error("memory request not held");
   property p_drop; mem_ack |=> !mem_req; endproperty
   a_drop: assert property (p_drop) else $error("memory request kept after ack");
   property p_align; mem_req |-> mem_addr[1:0] == 2'b00; endproperty
   a_align: assert property (p_align) else $error("memory word not aligned");
   property p_gap; s_word_gap |-> mem_addr == $past(mem_addr, 2) + 32'h4; endproperty
   a_gap: assert property (p_gap) else $error("next word address wrong");
   property p_err; mem_err |=> !mem_req [*4]; endproperty
   a_err: assert property (p_err) else $error("memory access after bus error");
   property p_grant; $rose(chip_xfer_grant) |-> ##[1:4] !chip_xfer_request; endproperty
   a_grant: assert property (p_grant) else $error("chip request not released");
   property p_oe; $fell(chip_xfer_request) |-> !chip_data_oe; endproperty
   a_oe: assert property (p_oe) else $error("chip data still driven");
   property p_iflush;
      $fell(chip_xfer_request) && !$past(chip_data_oe) && chip_irq |-> ##[1:12] mem_req;
   endproperty
   a_iflush: assert property (p_iflush) else $error("chip interrupt did not flush byte");
endmodule : idb_dma_props
bind idb_dma idb_dma_props u_props (.hclk, .hresetn, .mem_req, .mem_ack, .mem_err, .mem_addr,
   .chip_xfer_request, .chip_xfer_grant, .chip_data_oe, .chip_irq);
`default_nettype wire

// ==== tb/idb_partner.sv ====
// Memory and controller-chip model facing the DMA engine.
// Assumes the bench sets the faulting address and the memory delay.
`timescale 1ns/10ps
`default_nettype none
module idb_partner (
   input  wire logic        hclk,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [3:0]  mem_be,
   input  wire logic [31:0] mem_wdata,
   output logic      [31:0] mem_rdata,
   output logic             mem_ack,
   output logic             mem_err,
   input  wire logic [31:0] err_addr,
   input  wire logic [1:0]  slow,
   input  wire logic        chip_xfer_request,
   output logic             chip_xfer_grant,
   output logic      [7:0]  chip_data_in,
   input  wire logic [7:0]  chip_data_out,
   input  wire logic        chip_data_oe
);
   logic [31:0] mem [0:63];
   logic [7:0]  ob [0:63];
   int          nib = 0;
   int          nob = 0;
   int          dly = 0;
   initial {mem_rdata, mem_ack, mem_err, chip_xfer_grant, chip_data_in} = '0;
   always @(posedge hclk) begin
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      // Idle read lanes toggle so stale data never looks valid
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack && !mem_err) begin
         dly <= (dly < slow) ? dly + 1 : 0;
         if (dly >= slow && mem_addr === err_addr)
            mem_err <= 1'b1;
         else if (dly >= slow) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr[7:2]];
            for (int b = 0; b < 4; b++)
               if (mem_we && mem_be[b]) mem[mem_addr[7:2]][8*b +: 8] <= mem_wdata[8*b +: 8];
         end
      end
      if (!chip_xfer_request) begin
         chip_xfer_grant <= 1'b0;
         chip_data_in <= ~chip_data_in;
      end else if (!chip_xfer_grant) begin
         chip_xfer_grant <= 1'b1;
         if (chip_data_oe) begin
            ob[nob] <= chip_data_out;
            nob <= nob + 1;
         end else begin
            chip_data_in <= 8'h10 + 8'(nib);
            nib <= nib + 1;
         end
      end
   end
endmodule : idb_partner
`default_nettype wire

// ==== tb/tb_idb_dma.sv ====
// Self-checking bench of the instrument-bus DMA engine.
// Assumes the partner model stands in for memory and the chip.
`timescale 1ns/10ps
`default_nettype none
module tb_idb_dma;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, irq = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, err_addr = '1, q, hrdata, mem_addr, mem_wdata, mem_rdata;
   logic [1:0]  htrans = 2'b00, slow = 2'b00;
   logic [3:0]  mem_be;
   logic [7:0]  chip_data_in, chip_data_out;
   logic        hreadyout, hresp, mem_req, mem_we, mem_ack, mem_err, dma_irq;
   logic        chip_xfer_request, chip_xfer_grant, chip_data_oe;
   int          bad_count = 0, n_checks = 0, cyc = 0;
   idb_dma dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .mem_req, .mem_we, .mem_addr, .mem_be,
      .mem_wdata, .mem_rdata, .mem_ack, .mem_err, .chip_xfer_request, .chip_xfer_grant,
      .chip_data_in, .chip_data_out, .chip_data_oe, .chip_irq(irq), .dma_irq);
   idb_partner u_part (.hclk, .mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata, .mem_rdata,
      .mem_ack, .mem_err, .err_addr, .slow, .chip_xfer_request, .chip_xfer_grant, .chip_data_in,
      .chip_data_out, .chip_data_oe);
   initial forever #2 hclk = ~hclk;
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus
   // Enables, then polls until the engine goes quiet
   task automatic run();
      bus(1'b1, idb_pkg::OFS_ENABLE, 32'h3);
      repeat (4) @(posedge hclk);
      do bus(1'b0, idb_pkg::OFS_STATUS, '0); while (q[idb_pkg::ST_BUSY] !== 1'b0);
   endtask : run
   task automatic go(input logic [31:0] a, input logic [31:0] c, input logic [31:0] m, input logic [31:0] ctl);
      bus(1'b1, idb_pkg::OFS_ADDR, a);
      bus(1'b1, idb_pkg::OFS_COUNT, c);
      bus(1'b1, idb_pkg::OFS_MATCH, m);
      bus(1'b1, idb_pkg::OFS_CTRL, ctl);
      run();
   endtask : go
   task automatic t_tc();
      go(32'h0, 32'd35, 32'h0, 32'h0);
      for (int i = 0; i < 35; i++) chk("in_byte", u_part.mem[i/4][8*(i%4) +: 8], 32'h10 + i);
      chk("status_tc", q[idb_pkg::ST_TC], 1'b1);
      chk("irq", dma_irq, 1'b1);
      bus(1'b0, 8'h18, '0);
      chk("unmapped", q, 32'h0);
      $display("test tc done");
   endtask : t_tc
   task automatic t_match();
      go(32'h80, 32'd100, 32'h37, 32'h2);
      bus(1'b0, idb_pkg::OFS_COUNT, '0);
      chk("count_left", q, 32'd95);
      chk("match_byte", u_part.mem[33][7:0], 8'h37);
      irq <= 1'b1;
      run();
      irq <= 1'b0;
      chk("last_byte", u_part.mem[56][31:24], 8'h96);
      $display("test match done");
   endtask : t_match
   task automatic t_out();
      slow <= 2'd2;
      go(32'h0, 32'd8, 32'h0, 32'h1);
      for (int i = 0; i < 8; i++) chk("out_byte", u_part.ob[i], 8'h10 + i);
      err_addr <= 32'h20;
      go(32'h20, 32'd32, 32'h0, 32'h1);
      chk("buserr", q[idb_pkg::ST_BUSERR], 1'b1);
      chk("out_count", u_part.nob, 32'd8);
      bus(1'b0, idb_pkg::OFS_ENABLE, '0);
      chk("dmaen", q[idb_pkg::EN_DMA], 1'b0);
      $display("test out done");
   endtask : t_out
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         complete_run();
      end
   end
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_tc();
      t_match();
      t_out();
      complete_run();
   end
endmodule : tb_idb_dma
`default_nettype wire
